// ==== block_protect_params.svh ====
// Constants for the block protect and serial bit control logic
`ifndef BLOCK_PROTECT_PARAMS_SVH
`define BLOCK_PROTECT_PARAMS_SVH
// ---------------------------------------------------------------
// Serial bit space layout
// ---------------------------------------------------------------
`define BP_WP_LO        0
`define BP_XP_LO        4
`define BP_VIOL_CLR     8
`define BP_WVIOL_STAT   8
`define BP_XVIOL_STAT   9
`define BP_BOARD_DIS    9
`define BP_USER_LED     10
`define BP_ACC_CLR      11
`define BP_ACC_STAT     11
`define BP_FLAG_LO      12
`define BP_NBLK         4
`define BP_NBITS        16
// ---------------------------------------------------------------
// Address fields
// ---------------------------------------------------------------
`define BP_A0_POS       15
`define BP_BASE_HI      10
`define BP_BASE_LO      3
`define BP_HALF_BIT     11
`define BP_BIT_HI       14
`define BP_BIT_LO       12
`define BP_BLK_HI       13
`define BP_BLK_LO       12
// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define BP_CTRL_RST     16'h0000
`endif

// ==== block_protect_pkg.sv ====
// Types shared by the block protect logic
package block_protect_pkg;
  typedef logic [1:0]  blk_t;
  typedef logic [15:0] bits_t;
  // Serial bit access carrier
  typedef struct packed {
    logic [7:0] base_addr;
    logic       half;
    logic [2:0] bit_sel;
  } sio_addr_s;
  // Board option straps
  typedef struct packed {
    logic abort_on_violation_opt;
    logic soft_board_enable_opt;
    logic wp_polarity_opt;
    logic irq_level_en;
  } opts_s;
endpackage : block_protect_pkg

// ==== block_protect_cru_control.sv ====
// Block write and execute protection with serial control bits
`timescale 1ns/1ps
`include "block_protect_params.svh"

// Function
// R1 - Write cycle to write-protected block sets the write violation latch
// R2 - Instruction fetch from execute-protected block sets execute violation latch; one enables
// R3 - Bits 0-3 write protect blocks 0-3; bits 4-7 execute protect
// R4 - Abort option: write violation disables the memory block decoder
// R5 - Bit 8 zero clears both violation latches and holds them clear
// R6 - Host writes bit 8 one afterwards to re-arm violation latches
// R7 - Violation latches read at status bits 8 and 9
// R8 - Each violation latch drives active-low indicator; clear turns both off
// R9 - Bit 9 one deselects board when soft enable option chosen
// R10 - Bit 10 one lights active-low user indicator
// R11 - Board accessed latch reads bit 11; bit 11 zero clears it
// R12 - Bits 12-15 are flags reading back written value
// R13 - Violation latches ORed into one active-low interrupt request
// R14 - Interrupt issued only when a level is selected
// R15 - Option selects write-protect polarity of control bits
// R16 - Bits 0-7 read back the latched protect settings
// R17 - Base compare on A3-A10, A11 half, A12-A14 bit, write on strobe
// R18 - Block select from base-subtracted address picks 4096-byte block
module block_protect_cru_control (
  input  wire logic                         clock,               // 20 MHz bus clock
  input  wire logic                         rst,                 // Sync reset, high
  input  wire logic                         clk_en,              // Freezes state when low
  input  wire block_protect_pkg::opts_s     opts,                // Board option straps
  input  wire logic [7:0]                   sio_base,            // Configured serial base
  input  wire logic [3:0]                   mem_base,            // Memory base, A0-A3
  input  wire logic [15:0]                  addr,                // Address bus, bit 0 = A15
  input  wire logic                         mem_access,          // Address in board range
  input  wire logic                         bus_read_strobe,     // High on read, low on write
  input  wire logic                         mem_cycle,           // Memory cycle active
  input  wire logic                         instr_fetch_strobe_n,// Low on opcode fetch
  input  wire logic                         serial_io_wstrobe,   // Serial write strobe
  input  wire logic                         serial_io_wdata,     // Serial write bit
  output      logic                         serial_io_rdata,     // Serial read bit
  output      logic                         board_selected,      // Board memory enabled
  output      logic                         mem_block_zero,      // Addressed block is block 0
  output      logic                         decoder_en,          // Block decoder enable
  output      logic                         wviol_led_n,         // Write violation indicator
  output      logic                         xviol_led_n,         // Execute violation indicator
  output      logic                         user_led_n,          // User indicator
  output      logic                         irq_n                // Interrupt request
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic       wr_s;
  logic       fetch_s;
  logic       strb_s;
  logic       wdat_s;
  logic       macc_s;
  logic       strb_d_r;

  // Bus strobes come off the backplane, two stages before use
  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
      strb_d_r <= 1'b0;
    end else if (clk_en) begin
      sync1_r <= {mem_cycle & ~bus_read_strobe, ~instr_fetch_strobe_n,
                  serial_io_wstrobe, serial_io_wdata, mem_access};
      sync2_r <= sync1_r;
      strb_d_r <= strb_s;
    end
  end
  assign wr_s    = sync2_r[4];
  assign fetch_s = sync2_r[3];
  assign strb_s  = sync2_r[2];
  assign wdat_s  = sync2_r[1];
  assign macc_s  = sync2_r[0];

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  block_protect_pkg::sio_addr_s sa;
  block_protect_pkg::blk_t      blk;
  logic [3:0]                   blk_off;
  logic                         sio_hit;
  logic [3:0]                   bit_idx;

  // Address bus is numbered with A0 as the msb
  assign sa.base_addr = addr[`BP_A0_POS-`BP_BASE_LO -: 8];
  assign sa.half      = addr[`BP_A0_POS-`BP_HALF_BIT];
  assign sa.bit_sel   = addr[`BP_A0_POS-`BP_BIT_LO -: 3];
  assign sio_hit      = (sa.base_addr == sio_base); // R17
  assign bit_idx      = {sa.half, sa.bit_sel};
  // Base subtraction puts the lower bound at block 0
  assign blk_off      = addr[`BP_A0_POS -: 4] - mem_base; // R18
  assign blk          = blk_off[1:0]; // R18
  assign mem_block_zero = (blk == 2'h0);

  // ---------------------------------------------------------------
  // Control bit latches
  // ---------------------------------------------------------------
  logic [15:0] ctrl_r;

  // Written on the rising edge of the serial strobe only
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_r <= `BP_CTRL_RST;
    end else if (clk_en && strb_s && !strb_d_r && sio_hit) begin
      ctrl_r[bit_idx] <= wdat_s; // R17 R3 R12
    end
  end

  // ---------------------------------------------------------------
  // Protection lookup
  // ---------------------------------------------------------------
  logic [3:0] wp_eff;
  logic       wp_hit;
  logic       xp_hit;

  genvar g;
  generate
    for (g = 0; g < `BP_NBLK; g++) begin : g_wp
      // Polarity strap flips the sense of each write-protect bit
      assign wp_eff[g] = ctrl_r[`BP_WP_LO + g] ^ ~opts.wp_polarity_opt; // R15 R3
    end
  endgenerate
  assign wp_hit = wr_s & macc_s & wp_eff[blk]; // R1
  assign xp_hit = fetch_s & macc_s & ctrl_r[`BP_XP_LO + blk]; // R2

  // ---------------------------------------------------------------
  // Violation and access latches
  // ---------------------------------------------------------------
  logic wviol_r;
  logic xviol_r;
  logic acc_r;

  // A held-low clear bit dominates; capture only once re-armed
  always_ff @(posedge clock) begin
    if (rst) begin
      wviol_r <= 1'b0;
      xviol_r <= 1'b0;
    end else if (clk_en) begin
      if (!ctrl_r[`BP_VIOL_CLR]) begin
        wviol_r <= 1'b0; // R5
        xviol_r <= 1'b0; // R5
      end else begin
        if (wp_hit) wviol_r <= 1'b1; // R1
        if (xp_hit) xviol_r <= 1'b1; // R2
      end
    end
  end

  // Board-access latch, cleared while bit 11 is zero
  always_ff @(posedge clock) begin
    if (rst) begin
      acc_r <= 1'b0;
    end else if (clk_en) begin
      if (!ctrl_r[`BP_ACC_CLR]) acc_r <= 1'b0; // R11
      else if (board_selected) acc_r <= 1'b1; // R11
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  logic [15:0] rd_bits;

  // Board select gated by soft disable only with that option strapped
  assign board_selected = macc_s & ~(opts.soft_board_enable_opt & ctrl_r[`BP_BOARD_DIS]); // R9
  // Combinational abort: the write is killed in the same cycle it is seen
  assign decoder_en = board_selected & ~(opts.abort_on_violation_opt & wp_hit); // R4
  assign wviol_led_n = ~wviol_r; // R8
  assign xviol_led_n = ~xviol_r; // R8
  assign user_led_n  = ~ctrl_r[`BP_USER_LED]; // R10
  assign irq_n = ~((wviol_r | xviol_r) & opts.irq_level_en); // R13 R14

  // Read image: settings low, status and flags high
  always_comb begin
    rd_bits = ctrl_r; // R16 R12
    rd_bits[`BP_WVIOL_STAT] = wviol_r; // R7
    rd_bits[`BP_XVIOL_STAT] = xviol_r; // R7
    rd_bits[`BP_ACC_STAT]   = acc_r; // R11
  end

  // Registered read bit, so serial reads lag address by one clock
  always_ff @(posedge clock) begin
    if (rst) begin
      serial_io_rdata <= 1'b0;
    end else if (clk_en) begin
      serial_io_rdata <= sio_hit & rd_bits[bit_idx]; // R17
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_wviol_set;
    @(posedge clock) disable iff (rst)
      (clk_en && ctrl_r[`BP_VIOL_CLR] && wp_hit) |=> wviol_r;
  endproperty
  a_wviol_set: assert property (p_wviol_set) else $error("write violation not latched"); // R1

  property p_xviol_set;
    @(posedge clock) disable iff (rst)
      (clk_en && ctrl_r[`BP_VIOL_CLR] && xp_hit) |=> xviol_r;
  endproperty
  a_xviol_set: assert property (p_xviol_set) else $error("execute violation not latched"); // R2

  property p_abort;
    @(posedge clock) disable iff (rst)
      (opts.abort_on_violation_opt && wr_s && macc_s &&
       (ctrl_r[`BP_WP_LO + blk] == opts.wp_polarity_opt)) |-> !decoder_en;
  endproperty
  a_abort: assert property (p_abort) else $error("protected write reached decoder"); // R4

  property p_clear;
    @(posedge clock) disable iff (rst)
      (clk_en && !ctrl_r[`BP_VIOL_CLR]) |=> (!wviol_r && !xviol_r && irq_n);
  endproperty
  a_clear: assert property (p_clear) else $error("violations not cleared"); // R5

  property p_irq;
    @(posedge clock) disable iff (rst)
      irq_n == !((wviol_led_n == 1'b0 || xviol_led_n == 1'b0) && opts.irq_level_en);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not tied to violations"); // R13

  property p_no_level;
    @(posedge clock) disable iff (rst)
      !opts.irq_level_en |-> irq_n;
  endproperty
  a_no_level: assert property (p_no_level) else $error("interrupt with no level"); // R14

  property p_board_dis;
    @(posedge clock) disable iff (rst)
      (opts.soft_board_enable_opt && ctrl_r[`BP_BOARD_DIS]) |-> !board_selected;
  endproperty
  a_board_dis: assert property (p_board_dis) else $error("board selected while disabled"); // R9

  property p_acc;
    @(posedge clock) disable iff (rst)
      (clk_en && board_selected && ctrl_r[`BP_ACC_CLR]) |=> acc_r;
  endproperty
  a_acc: assert property (p_acc) else $error("access latch missed"); // R11

  property p_led;
    @(posedge clock) disable iff (rst)
      (clk_en && strb_s && !strb_d_r && sio_hit && bit_idx == `BP_USER_LED) |=> (user_led_n == !$past(wdat_s));
  endproperty
  a_led: assert property (p_led) else $error("user indicator not lit"); // R10

endmodule : block_protect_cru_control

// ==== host_bus_model.sv ====
// Behavioural host: memory bus cycles and serial bit writes
`timescale 1ns/1ps
module host_bus_model (
  input  wire logic        clock,                // Bus clock
  input  wire logic [7:0]  sio_base,             // Serial base to address
  input  wire logic [3:0]  mem_base,             // Memory base to add
  output      logic [15:0] addr,                 // Address bus
  output      logic        mem_access,           // In board range
  output      logic        bus_read_strobe,      // Low on write
  output      logic        mem_cycle,            // Memory cycle
  output      logic        instr_fetch_strobe_n, // Low on fetch
  output      logic        serial_io_wstrobe,    // Serial strobe
  output      logic        serial_io_wdata       // Serial bit
);
  // Bus idle at start
  initial begin
    {addr, mem_access, mem_cycle, serial_io_wstrobe, serial_io_wdata} = '0;
    bus_read_strobe = 1'b1;
    instr_fetch_strobe_n = 1'b1;
  end
  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask : idle
  // Serial address: base on A3-A10, half on A11, bit on A12-A14
  task automatic sel(input logic [3:0] b);
    addr = {3'h0, sio_base, b[3], b[2:0], 1'b0};
  endtask : sel
  // Strobe held long enough for the two-flop sync, then a low gap
  task automatic swrite(input logic [3:0] b, input logic v);
    sel(b);
    serial_io_wdata = v;
    serial_io_wstrobe = 1'b1;
    idle(4);
    serial_io_wstrobe = 1'b0;
    serial_io_wdata = ~v; // Released line shows no stale value
    idle(3);
  endtask : swrite
  // Memory cycle held until synced hit and latch are visible
  task automatic mstart(input logic [1:0] blk, input logic wr, input logic fe);
    addr = {mem_base + {2'h0, blk}, 12'h000};
    {mem_access, mem_cycle} = 2'h3;
    bus_read_strobe = ~wr;
    instr_fetch_strobe_n = ~fe;
    idle(3);
  endtask : mstart
  task automatic mend();
    {mem_access, mem_cycle} = 2'h0;
    bus_read_strobe = 1'b1;
    instr_fetch_strobe_n = 1'b1;
    // Address held until the synced strobes have drained
    idle(2);
    addr = ~addr;
    idle(1);
  endtask : mend
endmodule : host_bus_model

// ==== tb_top.sv ====
// Self-checking bench for the block protect control logic
`timescale 1ns/1ps
`define CMP(nm, e, s) begin checked++; if ((s) !== (e)) begin failures++; \
  $display("BAD %s expected %b seen %b", nm, e, s); end end
module tb_top;
  typedef struct {int k; logic v;} note_s;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  block_protect_pkg::opts_s opts = 4'hf;
  logic [7:0] sio_base = 8'h00;
  logic [3:0] mem_base = 4'h0;
  wire logic [15:0] addr;
  wire logic mem_access, bus_read_strobe, mem_cycle, instr_fetch_strobe_n, serial_io_wstrobe, serial_io_wdata;
  logic serial_io_rdata, board_selected, mem_block_zero, decoder_en, wviol_led_n, xviol_led_n, user_led_n, irq_n;
  logic [7:0] outs;
  string nm[8] = '{"irq_n", "user_led_n", "xviol_led_n", "wviol_led_n", "decoder_en", "mem_block_zero",
                   "board_selected", "serial_io_rdata"};
  localparam int IRQ = 0, ULED = 1, XLED = 2, WLED = 3, DEC = 4, ZB = 5, BSEL = 6, RD = 7;
  int failures = 0;
  int checked = 0;
  note_s notes[$];
  event look;
  assign outs = {serial_io_rdata, board_selected, mem_block_zero, decoder_en, wviol_led_n, xviol_led_n,
                 user_led_n, irq_n};
  always #25 clock = ~clock;
  block_protect_cru_control i_block_protect_cru_control (.clock(clock), .rst(rst), .clk_en(clk_en), .opts(opts),
    .sio_base(sio_base), .mem_base(mem_base), .addr(addr), .mem_access(mem_access),
    .bus_read_strobe(bus_read_strobe), .mem_cycle(mem_cycle), .instr_fetch_strobe_n(instr_fetch_strobe_n),
    .serial_io_wstrobe(serial_io_wstrobe), .serial_io_wdata(serial_io_wdata), .serial_io_rdata(serial_io_rdata),
    .board_selected(board_selected), .mem_block_zero(mem_block_zero), .decoder_en(decoder_en),
    .wviol_led_n(wviol_led_n), .xviol_led_n(xviol_led_n), .user_led_n(user_led_n), .irq_n(irq_n));
  host_bus_model i_host_bus_model (.clock(clock), .sio_base(sio_base), .mem_base(mem_base), .addr(addr),
    .mem_access(mem_access), .bus_read_strobe(bus_read_strobe), .mem_cycle(mem_cycle),
    .instr_fetch_strobe_n(instr_fetch_strobe_n), .serial_io_wstrobe(serial_io_wstrobe),
    .serial_io_wdata(serial_io_wdata));
  // Monitor drains notes against the settled outputs
  always @(look) begin : mon
    note_s n;
    while (notes.size() > 0) begin
      n = notes.pop_front();
      `CMP(nm[n.k], n.v, outs[n.k])
    end
  end
  // Driver waits for the monitor so outputs cannot move under it
  task automatic expect_out(input int k, input logic v);
    notes.push_back('{k, v});
    ->look;
    wait (notes.size() == 0);
  endtask : expect_out
  task automatic wr(input logic [3:0] b, input logic v);
    i_host_bus_model.swrite(b, v);
  endtask : wr
  task automatic rd(input logic [3:0] b, input logic v);
    i_host_bus_model.sel(b);
    i_host_bus_model.idle(2);
    expect_out(RD, v);
  endtask : rd
  task automatic summarize();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  // Watchdog cuts a hang short
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    summarize();
  end
  // Main sequence
  initial begin
    logic [3:0] fl;
    void'($urandom(41));
    sio_base = 8'($urandom);
    mem_base = 4'($urandom);
    fl = 4'($urandom);
    repeat (6) @(negedge clock);
    rst = 1'b0;
    expect_out(WLED, 1'b1);
    expect_out(IRQ, 1'b1);
    expect_out(ULED, 1'b1);
    wr(8, 1'b1);
    wr(11, 1'b1);
    for (int b = 0; b < 4; b++) begin
      wr(4'(b), 1'b1);
      rd(4'(b), 1'b1);
      i_host_bus_model.mstart(2'(b ^ 1), 1'b1, 1'b0);
      expect_out(DEC, 1'b1);
      i_host_bus_model.mend();
      expect_out(WLED, 1'b1);
      i_host_bus_model.mstart(2'(b), 1'b1, 1'b0);
      expect_out(DEC, 1'b0);
      expect_out(ZB, b == 0);
      i_host_bus_model.mend();
      expect_out(WLED, 1'b0);
      expect_out(IRQ, 1'b0);
      rd(8, 1'b1);
      wr(8, 1'b0);
      expect_out(WLED, 1'b1);
      i_host_bus_model.mstart(2'(b), 1'b1, 1'b0);
      i_host_bus_model.mend();
      expect_out(IRQ, 1'b1);
      wr(8, 1'b1);
      wr(4'(b), 1'b0);
      wr(4'(4 + b), 1'b1);
      i_host_bus_model.mstart(2'(b), 1'b0, 1'b1);
      i_host_bus_model.mend();
      expect_out(XLED, 1'b0);
      rd(9, 1'b1);
      wr(8, 1'b0);
      expect_out(XLED, 1'b1);
      wr(8, 1'b1);
      wr(4'(4 + b), 1'b0);
    end
    opts.wp_polarity_opt = 1'b0;
    opts.irq_level_en = 1'b0;
    i_host_bus_model.mstart(2'h2, 1'b1, 1'b0);
    i_host_bus_model.mend();
    expect_out(WLED, 1'b0);
    expect_out(IRQ, 1'b1);
    wr(8, 1'b0);
    wr(8, 1'b1);
    opts = 4'hf;
    wr(9, 1'b1);
    i_host_bus_model.mstart(2'h1, 1'b0, 1'b0);
    expect_out(BSEL, 1'b0);
    i_host_bus_model.mend();
    // Options off: bit 9 ignored, violation no longer aborts
    opts = 4'h3;
    wr(0, 1'b1);
    i_host_bus_model.mstart(2'h0, 1'b1, 1'b0);
    expect_out(BSEL, 1'b1);
    expect_out(DEC, 1'b1);
    i_host_bus_model.mend();
    expect_out(WLED, 1'b0);
    wr(8, 1'b0);
    wr(8, 1'b1);
    wr(0, 1'b0);
    wr(9, 1'b0);
    opts = 4'hf;
    // Frozen clock enable must swallow a serial write
    clk_en = 1'b0;
    wr(10, 1'b1);
    expect_out(ULED, 1'b1);
    clk_en = 1'b1;
    wr(10, 1'b1);
    expect_out(ULED, 1'b0);
    wr(10, 1'b0);
    expect_out(ULED, 1'b1);
    rd(11, 1'b1);
    wr(11, 1'b0);
    rd(11, 1'b0);
    for (int i = 0; i < 4; i++) wr(4'(12 + i), fl[i]);
    for (int i = 0; i < 4; i++) rd(4'(12 + i), fl[i]);
    summarize();
  end
endmodule : tb_top
